// ===== tb/compact_timer_compare_pwm_tb_top.sv
// self-checking testbench of the compact timer
`include "ctp_regs.svh"
// ----
// bench
// ----
module compact_timer_compare_pwm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] o_c0  = `CTP_OFS_CTRL0;
  localparam logic [4:0] o_clo = `CTP_OFS_CNT_LO;
  localparam logic [4:0] o_alo = `CTP_OFS_CMPA_LO;
  localparam logic [4:0] o_ahi = `CTP_OFS_CMPA_HI;
  localparam logic [4:0] o_st  = `CTP_OFS_STATUS;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        ext_clk_pin_i = 1'b0;
  logic        pin_o;
  logic        pin_en_o;
  wire         pin_level;
  int          hi_len;
  int          per_len;
  int          edges;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed = 32'hc5552839;
  int          ck[6] = '{1, 0, 2, 3, 6, 7};
  int          dv[6] = '{1, 4, 16, 64, 12, 12};
  logic [7:0]  pm[5] = '{8'ha8, 8'ha9, 8'hac, 8'ha4, 8'ha0};
  int          ph[5] = '{32, 32, 96, 32, 96};
  // released pin is pulled down
  assign pin_level = pin_en_o ? pin_o : 1'b0;
  always #5 clk_sys_i = ~clk_sys_i;
  always begin
    repeat (6) @(posedge clk_sys_i);
    ext_clk_pin_i <= ~ext_clk_pin_i;
  end
  ctp_timer ctp_timer_inst (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .ext_clk_pin_i(ext_clk_pin_i),
    .timer_output_pin_o(pin_o),
    .timer_output_pin_en_o(pin_en_o)
  );
  ctp_pin_load ctp_pin_load_inst (
    .clk_sys_i(clk_sys_i),
    .level_i(pin_level),
    .hi_len_o(hi_len),
    .per_len_o(per_len),
    .edges_o(edges)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      fail_count++;
      $display("[ERR] %0t bus timeout", $time);
    end
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, e});
  endtask
  // stop, configure, clear flags, then start the counter
  task automatic run(input logic [7:0] c1, input logic [2:0] per, input logic [2:0] cs,
                     input logic [9:0] a);
    wr(o_c0, 8'h00);
    wr(`CTP_OFS_CTRL1, c1);
    wr(o_alo, a[7:0]);
    wr(o_ahi, {6'h0, a[9:8]});
    wr(o_st, 8'h03);
    wr(o_c0, {1'b0, cs, 1'b1, per});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end
  initial begin
    logic [7:0] q;
    int v;
    int e0;
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(o_alo, 8'h00);
    rd(o_ahi, 8'h00);
    wr(o_ahi, 8'hff);
    rd(o_ahi, 8'h03);
    wr(o_alo, 8'ha5);
    avs_byteenable_i <= 4'h0;
    wr(o_alo, 8'h5a);
    avs_byteenable_i <= 4'hf;
    rd(o_alo, 8'ha5);
    rd(5'h1c, 8'h00);
    done("registers");
    for (int i = 0; i < 6; i++) begin
      v = 3 + ($random(seed) & 7);
      run(8'h31, 3'h0, ck[i][2:0], v[9:0]);
      cycles(4 * v * dv[i] + 100);
      chk(hi_len, v * dv[i]);
      chk(per_len, 2 * v * dv[i]);
      rd(o_st, 8'h01);
    end
    done("clock sources");
    run(8'h30, 3'h1, 3'h1, 10'h032);
    cycles(600);
    chk(hi_len, 128);
    rd(o_st, 8'h03);
    run(8'h31, 3'h1, 3'h1, 10'h000);
    cycles(10);
    e0 = edges;
    cycles(2200);
    chk(edges, e0);
    rd(o_st, 8'h00);
    run(8'h18, 3'h0, 3'h1, 10'h0c8);
    cycles(20);
    chk(pin_level, 1'b1);
    cycles(300);
    chk(pin_level, 1'b0);
    run(8'h08, 3'h0, 3'h1, 10'h014);
    cycles(300);
    chk(pin_level, 1'b1);
    run(8'hf1, 3'h0, 3'h1, 10'h00a);
    cycles(100);
    chk(pin_en_o, 1'b0);
    rd(o_st, 8'h01);
    done("compare and timer");
    for (int i = 0; i < 5; i++) begin
      run(pm[i], 3'h1, 3'h1, 10'h020);
      cycles(400);
      chk(hi_len, ph[i]);
      chk(per_len, 128);
      rd(o_st, 8'h03);
    end
    run(8'ha8, 3'h0, 3'h1, 10'h020);
    cycles(2200);
    chk(per_len, 1024);
    run(8'haa, 3'h1, 3'h1, 10'h12c);
    cycles(800);
    chk(hi_len, 128);
    chk(per_len, 300);
    run(8'haa, 3'h1, 3'h1, 10'h064);
    cycles(20);
    e0 = edges;
    cycles(400);
    chk(edges, e0);
    chk(pin_level, 1'b1);
    run(8'h98, 3'h1, 3'h1, 10'h020);
    cycles(300);
    chk(pin_level, 1'b1);
    rd(o_st, 8'h03);
    run(8'h88, 3'h1, 3'h1, 10'h020);
    cycles(300);
    chk(pin_level, 1'b0);
    done("pwm");
    run(8'h31, 3'h0, 3'h1, 10'h000);
    cycles(50);
    wr(o_c0, 8'h98);
    bus(1'b0, o_clo, 8'h00, q);
    cycles(30);
    rd(o_clo, q);
    wr(o_c0, 8'h10);
    bus(1'b0, o_clo, 8'h00, q);
    cycles(30);
    rd(o_clo, q);
    wr(o_c0, 8'h18);
    bus(1'b0, o_clo, 8'h00, q);
    chk({31'h0, q < 8'h10}, 32'h1);
    done("pause and enable");
    end_of_test();
  end
endmodule

// ===== tb/ctp_pin_load.sv
// load circuit on the timer output pin: measures pulse widths and edges
// ----
// pin load
// ----
module ctp_pin_load (
  input  wire logic clk_sys_i,
  input  wire logic level_i,
  output int        hi_len_o,
  output int        per_len_o,
  output int        edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   hi_cnt = 0;
  int   per_cnt = 0;
  logic prev = 1'b0;
  initial begin
    hi_len_o = 0;
    per_len_o = 0;
    edges_o = 0;
  end
  // widths are counted in whole clock cycles between sampled edges
  always @(posedge clk_sys_i) begin
    per_cnt <= per_cnt + 1;
    hi_cnt  <= level_i ? hi_cnt + 1 : 0;
    prev    <= level_i;
    if (level_i !== prev) edges_o <= edges_o + 1;
    if (level_i && !prev) begin
      per_len_o <= per_cnt;
      per_cnt   <= 1;
    end
    if (!level_i && prev) hi_len_o <= hi_cnt;
  end
endmodule

// ===== verilog/ctp_clk_sel.sv
// counter clock source selection: prescaled ticks, sub clock tick and pin edges
`include "ctp_regs.svh"

module ctp_clk_sel
  import ctp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] clk_sel_i,
  input  wire logic       ext_clk_i,
  output logic            tick_o
);

  ctp_clk_state_t s;
  ctp_clk_state_t n;

  //----------------------------------------------------------------------------
  // prescalers and pin synchroniser
  //----------------------------------------------------------------------------
  always_comb begin
    n          = s;
    n.pin_s1   = ext_clk_i;
    n.pin_s2   = s.pin_s1;
    n.pin_prev = s.pin_s2;
    n.pre      = s.pre + 6'h01;
    if (s.sub_cnt == 12'(`CTP_SUB_DIV - 1)) begin
      n.sub_cnt = 12'h000;
    end else begin
      n.sub_cnt = s.sub_cnt + 12'h001;
    end
    case (clk_sel_i)
      `CTP_CK_SYS4:     tick_o = (s.pre[1:0] == 2'h3);
      `CTP_CK_SYS:      tick_o = 1'b1;
      `CTP_CK_H16:      tick_o = (s.pre[3:0] == 4'hf);
      `CTP_CK_H64:      tick_o = (s.pre == 6'h3f);
      `CTP_CK_SUB0,
      `CTP_CK_SUB1:     tick_o = (s.sub_cnt == 12'(`CTP_SUB_DIV - 1));
      `CTP_CK_PIN_RISE: tick_o = s.pin_s2 && !s.pin_prev;
      `CTP_CK_PIN_FALL: tick_o = !s.pin_s2 && s.pin_prev;
      default:          tick_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule

// ===== verilog/ctp_pkg.sv
// types shared by the compact timer modules
package ctp_pkg;

  typedef struct packed {
    logic       waitreq;
    logic [7:0] rdata;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [9:0] compare_a_value;
    logic [9:0] cnt;
    logic       flag_a;
    logic       flag_p;
    logic       on_prev;
    logic       cmp_lvl;
    logic       pin_out;
    logic       pin_en;
  } ctp_state_t;

  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_prev;
    logic [5:0]  pre;
    logic [11:0] sub_cnt;
  } ctp_clk_state_t;

endpackage

// ===== verilog/ctp_regs.svh
// register map, field positions, reset values and timing counts of the compact timer
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

//------------------------------------------------------------------------------
// byte offsets on the register bus
//------------------------------------------------------------------------------
`define CTP_OFS_CTRL0     5'h00
`define CTP_OFS_CTRL1     5'h04
`define CTP_OFS_CNT_LO    5'h08
`define CTP_OFS_CNT_HI    5'h0c
`define CTP_OFS_CMPA_LO   5'h10
`define CTP_OFS_CMPA_HI   5'h14
`define CTP_OFS_STATUS    5'h18

//------------------------------------------------------------------------------
// field positions
//------------------------------------------------------------------------------
`define CTP_C0_PAUSE      7
`define CTP_C0_CKSEL_HI   6
`define CTP_C0_CKSEL_LO   4
`define CTP_C0_ON         3
`define CTP_C0_PER_HI     2
`define CTP_C0_PER_LO     0
`define CTP_C1_MODE_HI    7
`define CTP_C1_MODE_LO    6
`define CTP_C1_ACT_HI     5
`define CTP_C1_ACT_LO     4
`define CTP_C1_INIT       3
`define CTP_C1_INV        2
`define CTP_C1_SWAP       1
`define CTP_C1_CLRSEL     0
`define CTP_ST_FLAG_A     0
`define CTP_ST_FLAG_P     1

//------------------------------------------------------------------------------
// encodings and reset values
//------------------------------------------------------------------------------
`define CTP_MODE_CMP      2'h0
`define CTP_MODE_PWM      2'h2
`define CTP_MODE_TMR      2'h3
`define CTP_ACT_NONE      2'h0
`define CTP_ACT_LOW       2'h1
`define CTP_ACT_HIGH      2'h2
`define CTP_ACT_TOG       2'h3
`define CTP_PWM_INACT     2'h0
`define CTP_PWM_ACT       2'h1
`define CTP_PWM_WAVE      2'h2
`define CTP_CK_SYS4       3'h0
`define CTP_CK_SYS        3'h1
`define CTP_CK_H16        3'h2
`define CTP_CK_H64        3'h3
`define CTP_CK_SUB0       3'h4
`define CTP_CK_SUB1       3'h5
`define CTP_CK_PIN_RISE   3'h6
`define CTP_CK_PIN_FALL   3'h7
`define CTP_RST_BYTE      8'h00
`define CTP_PER_FULL      11'h400

//------------------------------------------------------------------------------
// timing: sub clock tick derived from the system clock
//------------------------------------------------------------------------------
`define CTP_SYS_HZ        100000000
`define CTP_SUB_HZ        32768
`define CTP_SUB_DIV       (`CTP_SYS_HZ / `CTP_SUB_HZ)

`endif

// ===== verilog/ctp_timer.sv
// compact 10-bit timer with compare A / period P, compare, timer and PWM modes
`include "ctp_regs.svh"

module ctp_timer
  import ctp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        ext_clk_pin_i,
  output logic             timer_output_pin_o,
  output logic             timer_output_pin_en_o
);

  ctp_state_t  s;
  ctp_state_t  n;
  logic        tick;
  logic        req;
  logic        wr_stb;
  logic [1:0]  mode;
  logic [1:0]  act;
  logic [2:0]  period_value;
  logic        init_lvl;
  logic        inv;
  logic        swap;
  logic        clrsel;
  logic        is_pwm;
  logic        on_rise;
  logic        run;
  logic [10:0] sum;
  logic [10:0] per_p;
  logic [10:0] duty;
  logic        hit_a;
  logic        hit_p;
  logic        ovf;
  logic        wrap;
  logic        set_a;
  logic        set_p;
  logic        clr_a;
  logic        clr_p;
  logic        pwm_lvl;

  //----------------------------------------------------------------------------
  // read mux
  //----------------------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input ctp_state_t st, input logic [4:0] a);
    logic [7:0] d;
    d = `CTP_RST_BYTE;
    case (a)
      `CTP_OFS_CTRL0:   d = st.ctl0;
      `CTP_OFS_CTRL1:   d = st.ctl1;
      `CTP_OFS_CNT_LO:  d = st.cnt[7:0];
      `CTP_OFS_CNT_HI:  d = {6'h00, st.cnt[9:8]};
      `CTP_OFS_CMPA_LO: d = st.compare_a_value[7:0];
      `CTP_OFS_CMPA_HI: d = {6'h00, st.compare_a_value[9:8]};
      `CTP_OFS_STATUS:  d = {6'h00, st.flag_p, st.flag_a};
      default:          d = `CTP_RST_BYTE;
    endcase
    return d;
  endfunction

  //----------------------------------------------------------------------------
  // counter clock source
  //----------------------------------------------------------------------------
  ctp_clk_sel u_clk_sel (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .clk_sel_i (s.ctl0[`CTP_C0_CKSEL_HI:`CTP_C0_CKSEL_LO]),
    .ext_clk_i (ext_clk_pin_i),
    .tick_o    (tick)
  );

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    n        = s;
    mode     = s.ctl1[`CTP_C1_MODE_HI:`CTP_C1_MODE_LO];
    act      = s.ctl1[`CTP_C1_ACT_HI:`CTP_C1_ACT_LO];
    period_value     = s.ctl0[`CTP_C0_PER_HI:`CTP_C0_PER_LO];
    init_lvl = s.ctl1[`CTP_C1_INIT];
    inv      = s.ctl1[`CTP_C1_INV];
    swap     = s.ctl1[`CTP_C1_SWAP];
    clrsel   = s.ctl1[`CTP_C1_CLRSEL];
    is_pwm   = (mode == `CTP_MODE_PWM);

    // bus slave: one wait state, access committed while waitrequest is low
    req       = avs_read_i || avs_write_i;
    n.waitreq = !(req && s.waitreq);
    if (req && s.waitreq) begin
      n.rdata = rd_byte(s, avs_address_i);
    end
    wr_stb = avs_write_i && !s.waitreq && avs_byteenable_i[0];
    clr_a  = 1'b0;
    clr_p  = 1'b0;
    if (wr_stb) begin
      case (avs_address_i)
        `CTP_OFS_CTRL0:   n.ctl0 = avs_writedata_i[7:0];
        `CTP_OFS_CTRL1:   n.ctl1 = avs_writedata_i[7:0];
        `CTP_OFS_CMPA_LO: n.compare_a_value[7:0] = avs_writedata_i[7:0];
        `CTP_OFS_CMPA_HI: n.compare_a_value[9:8] = avs_writedata_i[1:0];
        `CTP_OFS_STATUS: begin
          clr_a = avs_writedata_i[`CTP_ST_FLAG_A];
          clr_p = avs_writedata_i[`CTP_ST_FLAG_P];
        end
        default: ;
      endcase
    end

    // counter enable and comparators
    n.on_prev = s.ctl0[`CTP_C0_ON];
    on_rise   = s.ctl0[`CTP_C0_ON] && !s.on_prev;
    run       = tick && s.ctl0[`CTP_C0_ON] && !s.ctl0[`CTP_C0_PAUSE] && !on_rise;
    sum       = {1'b0, s.cnt} + 11'h001;
    ovf       = sum[10];
    if (period_value == 3'h0) begin
      per_p = `CTP_PER_FULL;
    end else begin
      per_p = {1'b0, period_value, 7'h00};
    end
    hit_a = (s.compare_a_value != 10'h000) && (sum == {1'b0, s.compare_a_value});
    hit_p = (period_value != 3'h0) && (sum == per_p);

    if (is_pwm) begin
      wrap  = swap ? (hit_a || ovf) : (hit_p || ovf);
      set_a = hit_a;
      set_p = hit_p;
      duty  = swap ? per_p : {1'b0, s.compare_a_value};
    end else if (clrsel) begin
      wrap  = hit_a || ovf;
      set_a = hit_a;
      set_p = 1'b0;
      duty  = per_p;
    end else begin
      wrap  = hit_p || ovf;
      set_a = hit_a;
      set_p = hit_p;
      duty  = per_p;
    end
    set_a = set_a && run;
    set_p = set_p && run;

    if (on_rise) begin
      n.cnt = 10'h000;
    end else if (run) begin
      n.cnt = wrap ? 10'h000 : sum[9:0];
    end

    // flags: a hardware set wins over a software clear in the same cycle
    n.flag_a = (s.flag_a && !clr_a) || set_a;
    n.flag_p = (s.flag_p && !clr_p) || set_p;

    // compare mode pin level
    if (on_rise) begin
      n.cmp_lvl = init_lvl;
    end else if (set_a) begin
      case (act)
        `CTP_ACT_LOW:  n.cmp_lvl = 1'b0;
        `CTP_ACT_HIGH: n.cmp_lvl = 1'b1;
        `CTP_ACT_TOG:  n.cmp_lvl = !s.cmp_lvl;
        default:       n.cmp_lvl = s.cmp_lvl;
      endcase
    end

    // PWM level: active from clear until the count reaches the duty value
    case (act)
      `CTP_PWM_INACT: pwm_lvl = !init_lvl;
      `CTP_PWM_ACT:   pwm_lvl = init_lvl;
      `CTP_PWM_WAVE:  pwm_lvl = ({1'b0, n.cnt} < duty) ? init_lvl : !init_lvl;
      default:        pwm_lvl = !init_lvl;
    endcase

    n.pin_out = (is_pwm ? pwm_lvl : n.cmp_lvl) ^ inv;
    n.pin_en  = (mode == `CTP_MODE_CMP) || is_pwm;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s         <= '0;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata_o        = {24'h000000, s.rdata};
  assign avs_waitrequest_o     = s.waitreq;
  assign timer_output_pin_o    = s.pin_out;
  assign timer_output_pin_en_o = s.pin_en;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_high_byte_zero: assert property (
    (avs_read_i && s.waitreq && avs_address_i == `CTP_OFS_CMPA_HI)
    |=> (avs_readdata_o[7:2] == 6'h00 && !avs_waitrequest_o))
    else $error("compare A high byte upper bits not zero");

  a_no_flag_p: assert property (
    (!is_pwm && clrsel && !s.flag_p && !wr_stb) |=> !s.flag_p)
    else $error("period flag raised with clear_select high");

  a_on_clears_cnt: assert property (
    on_rise |=> (s.cnt == 10'h000 && s.cmp_lvl == $past(init_lvl)))
    else $error("counter_on rise did not clear counter or load level");

  a_pause_holds: assert property (
    (s.ctl0[`CTP_C0_PAUSE] && !on_rise) |=> (s.cnt == $past(s.cnt)))
    else $error("counter moved while paused");

  a_period_wrap: assert property (
    (is_pwm && !swap && period_value != 3'h0 && run && s.cnt == per_p[9:0] - 10'h001)
    |=> (s.cnt == 10'h000 && s.flag_p))
    else $error("period match did not clear counter");

  a_cmp_toggle: assert property (
    (!is_pwm && set_a && act == `CTP_ACT_TOG)
    |=> (s.cmp_lvl != $past(s.cmp_lvl)) ##1 (timer_output_pin_o == $past(s.cmp_lvl ^ inv)))
    else $error("toggle action did not flip the pin");

  a_tmr_no_pin: assert property (
    (mode == `CTP_MODE_TMR) |=> !timer_output_pin_en_o)
    else $error("timer mode drives the pin");

  a_pwm_full: assert property (
    (is_pwm && act == `CTP_PWM_WAVE && !swap && {1'b0, s.compare_a_value} >= per_p)
    |=> (timer_output_pin_o == $past(init_lvl ^ inv)))
    else $error("duty at or above period not fully active");

  a_zero_a_no_flag: assert property (
    (!is_pwm && clrsel && s.compare_a_value == 10'h000 && run && s.cnt == 10'h3ff)
    |=> (s.cnt == 10'h000 && s.flag_a == $past(s.flag_a && !clr_a)))
    else $error("zero compare A raised flag or failed to overflow");

  //----------------------------------------------------------------------------
  // flag, clear, pin, counter hold and bus checks
  //----------------------------------------------------------------------------
  a_flag_a_set: assert property (
    set_a |=> s.flag_a)
    else $error("comparator A match did not raise its flag");

  a_pwm_flag_p: assert property (
    (is_pwm && hit_p && run) |=> s.flag_p)
    else $error("period match in PWM mode did not raise its flag");

  a_cmp_p_quiet: assert property (
    (!is_pwm && !set_a && !on_rise) |=> (s.cmp_lvl == $past(s.cmp_lvl)))
    else $error("compare level moved without an A match");

  a_cmp_high: assert property (
    (!is_pwm && set_a && act == `CTP_ACT_HIGH) |=> s.cmp_lvl)
    else $error("high action did not raise the compare level");

  a_cmp_low: assert property (
    (!is_pwm && set_a && act == `CTP_ACT_LOW) |=> !s.cmp_lvl)
    else $error("low action did not drop the compare level");

  a_cmp_none: assert property (
    (!is_pwm && set_a && act == `CTP_ACT_NONE) |=> (s.cmp_lvl == $past(s.cmp_lvl)))
    else $error("no-change action moved the compare level");

  a_pwm_inact: assert property (
    (is_pwm && act == `CTP_PWM_INACT) |=> (timer_output_pin_o == $past(!init_lvl ^ inv)))
    else $error("forced inactive PWM level wrong");

  a_pwm_act: assert property (
    (is_pwm && act == `CTP_PWM_ACT) |=> (timer_output_pin_o == $past(init_lvl ^ inv)))
    else $error("forced active PWM level wrong");

  a_pwm_drives: assert property (
    is_pwm |=> timer_output_pin_en_o)
    else $error("PWM mode does not drive the pin");

  a_clr_on_a: assert property (
    (!is_pwm && clrsel && run && hit_a) |=> (s.cnt == 10'h000))
    else $error("A match did not clear the counter");

  a_ovf_clear: assert property (
    (!is_pwm && !clrsel && period_value == 3'h0 && run && s.cnt == 10'h3ff) |=> (s.cnt == 10'h000))
    else $error("overflow did not clear the counter");

  a_swap_wrap: assert property (
    (is_pwm && swap && run && hit_a) |=> (s.cnt == 10'h000))
    else $error("swapped PWM period did not clear on A match");

  a_off_holds: assert property (
    !s.ctl0[`CTP_C0_ON] |=> (s.cnt == $past(s.cnt)))
    else $error("counter moved while switched off");

  a_bus_answer: assert property (
    (req && s.waitreq) |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait state");

  a_bus_release: assert property (
    !s.waitreq |=> avs_waitrequest_o)
    else $error("waitrequest stayed low for more than one cycle");

endmodule
